// file: acs_analog_model.sv
// Behavioural model of the analog converter core behind the sequencer.
// Assumes the sequencer drives acs_analog_s and samples the comparator.
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model
  import acs_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Controls and the levels on the external and internal paths
  input wire acs_analog_s ctrl,
  input wire logic [11:0] ext_level,
  input wire logic [11:0] int_level,
  // Comparator toward the sequencer
  output logic comparator_high
);
  logic [11:0] level;

  ////////////////////////////////////////////////////////////////////////////
  // path routing; pin taken as set to analog input
  assign level = ctrl.ext_connect ? ext_level : int_level;

  // Start from a known level so the unpowered toggle is defined
  initial comparator_high = 1'b0;

  // level sits mid-step, so ties never occur
  // unpowered core gives a toggling, meaningless output
  always @(posedge pclk) begin
    if (ctrl.power_on) begin
      comparator_high <= ({level, 1'b1} > {ctrl.trial_code, 1'b0});
    end else begin
      comparator_high <= ~comparator_high;
    end
  end
endmodule
`default_nettype wire

// file: acs_clock_divider.sv
// Power-of-two divider making the converter clock period tick.
// Assumes restart is a same-clock pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module acs_clock_divider
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic restart,
  input wire logic [2:0] clock_sel,
  // One-cycle pulse at the end of each converter period
  output logic tick
);

  logic [6:0] count_q;
  logic [6:0] terminal;

  ////////////////////////////////////////////////////////////////////////////
  // RQ6 RQ17 ratio from select
  // Code 0 ends every cycle; each step doubles, up to 128
  assign terminal = 7'((8'h01 << clock_sel) - 8'h01);
  // Lowering the select ends the running period instead of wrapping at 128
  assign tick = (count_q >= terminal);

  // Restart aligns the first period to the launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= ACS_DIV_RST;
    end else if (restart || tick) begin
      count_q <= ACS_DIV_RST;
    end else begin
      count_q <= count_q + 7'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_div_bound: assert property ( // RQ17
    (count_q <= terminal) ##1 $stable(clock_sel) |-> count_q <= terminal)
    else $error("divider count beyond terminal");
  a_div_wrap: assert property (tick |=> count_q == 7'h00) // RQ6
    else $error("divider did not wrap after tick");

endmodule
`default_nettype wire

// file: acs_pkg.sv
// Shared constants, types and decode helpers for the conversion sequencer.
// Assumes a single 200 MHz system clock and an APB register port.
package acs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ACS_CTRL0_OFS = 8'h00;
  localparam logic [7:0] ACS_CTRL1_OFS = 8'h04;
  localparam logic [7:0] ACS_CTRL2_OFS = 8'h08;
  localparam logic [7:0] ACS_RESH_OFS = 8'h0c;
  localparam logic [7:0] ACS_RESL_OFS = 8'h10;
  localparam logic [7:0] ACS_IRQ_OFS = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ACS_START_POS = 0;
  localparam int ACS_POWER_POS = 1;
  localparam int ACS_CHAN_POS = 2;
  localparam int ACS_BUSY_POS = 7;
  localparam int ACS_CLKSEL_POS = 0;
  localparam int ACS_SRC_POS = 4;
  localparam int ACS_FMT_POS = 8;
  localparam int ACS_REF_POS = 0;
  localparam int ACS_GAIN_POS = 2;
  localparam int ACS_AMPIN_POS = 5;
  localparam int ACS_GIE_POS = 0;
  localparam int ACS_CIE_POS = 1;
  localparam int ACS_REQ_POS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [5:0] ACS_CTRL0_RST = 6'h00;
  localparam logic [8:0] ACS_CTRL1_RST = 9'h000;
  localparam logic [6:0] ACS_CTRL2_RST = 7'h00;
  localparam logic [1:0] ACS_IRQ_RST = 2'h0;
  localparam logic [11:0] ACS_CODE_RST = 12'h000;
  localparam logic [7:0] ACS_BYTE_RST = 8'h00;
  localparam logic [6:0] ACS_DIV_RST = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts, in converter clock periods, and the result MSB index
  localparam logic [3:0] ACS_SAMPLE_PERIODS = 4'h4;
  localparam logic [3:0] ACS_CONVERT_PERIODS = 4'hc;
  localparam logic [3:0] ACS_SAMPLE_LAST = ACS_SAMPLE_PERIODS - 4'h1;
  localparam logic [3:0] ACS_CONVERT_LAST = ACS_CONVERT_PERIODS - 4'h1;
  localparam logic [3:0] ACS_MSB_INDEX = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_SAMPLE = 2'b01,
    ACS_CONVERT = 2'b11,
    ACS_DONE = 2'b10
  } acs_state_e;

  // Controls toward the analog converter core
  typedef struct packed {
    logic power_on;
    logic sample_hold;
    logic ext_connect;
    logic [3:0] source_sel;
    logic [3:0] channel_sel;
    logic [1:0] reference_sel;
    logic [1:0] amp_input;
    logic [2:0] amp_gain;
    logic [11:0] trial_code;
  } acs_analog_s;

  ////////////////////////////////////////////////////////////////////////////
  // Source codes 0000, 0100 and 11xx route an external pin
  function automatic logic acs_is_external(input logic [3:0] src);
    return (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'b11);
  endfunction

endpackage

// file: acs_result_format.sv
// Arranges the 12-bit code into the high and low result bytes.
// Pure combinational; the caller registers the bytes.
`timescale 1ns/1ps
`default_nettype none
module acs_result_format
  import acs_pkg::*;
(
  // Code and format
  input wire logic [11:0] code,
  input wire logic format_sel,
  // Byte images
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);

  ////////////////////////////////////////////////////////////////////////////
  // RQ11 byte arrangement
  // 0: left aligned in high byte; 1: right aligned, top nibble zero
  always_comb begin
    if (format_sel) begin
      high_byte = {4'h0, code[11:8]};
      low_byte = code[7:0];
    end else begin
      high_byte = code[11:4];
      low_byte = {code[3:0], 4'h0};
    end
  end

endmodule
`default_nettype wire

// file: acs_sequencer.sv
// Conversion sequencer for a 12-bit successive-approximation converter.
// Assumes an APB master on pclk and an analog core with a comparator pin.
//
// Operation
// RQ1 - Four periods sampling, twelve converting, sixteen in total.
// RQ2 - Start bit low, high, low begins a conversion.
// RQ3 - Busy flag stays high throughout a conversion.
// RQ4 - At the end busy drops and result bytes update.
// RQ5 - Conversion runs in hardware; processor never stalled.
// RQ6 - Converter clock divided from system clock by select field.
// RQ7 - Converter powered only while enable bit is one.
// RQ8 - Enable zero switches converter circuits fully off.
// RQ9 - Sources 0000, 0100, 11xx convert the selected external channel.
// RQ10 - Internal sources disconnect the external channel automatically.
// RQ11 - Result format bit arranges bits in the two bytes.
// RQ12 - Reference select chosen; amplifier input and gain apply.
// RQ13 - Interrupt delivered only with global and converter enables set.
// RQ14 - Result is a 12-bit unsigned code, full scale FFF.
// RQ15 - Software configures pin function before external conversions.
// RQ16 - Completion sets the converter interrupt request flag.
// RQ17 - Clock select divides by two to the code, up to 128.
// RQ18 - Busy set as soon as a conversion is launched.
// RQ19 - Start rising edge aborts; falling edge launches.
// RQ20 - After reset busy reads zero, converter powered off.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog converter core
  input wire logic comparator_high,
  output acs_analog_s analog_ctrl,
  // Interrupt toward the core
  output logic conv_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [5:0] ctrl0_q;
  logic [8:0] ctrl1_q;
  logic [6:0] ctrl2_q;
  logic [1:0] irq_en_q;
  logic conv_irq_request_q;
  logic start_prev_q;
  logic conv_busy_flag_q;
  acs_state_e state_q;
  logic [3:0] period_q;
  logic [11:0] sar_q;
  logic [7:0] result_high_byte_q;
  logic [7:0] result_low_byte_q;
  logic [31:0] prdata_q;
  logic [2:0] comp_sync_q;
  logic comp_q;
  logic access;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rd_data;
  logic start_bit;
  logic conv_power_enable;
  logic [3:0] external_channel_select;
  logic [2:0] conv_clock_select;
  logic [3:0] input_source_select;
  logic result_format_select;
  logic [1:0] reference_select;
  logic global_irq_enable;
  logic conv_irq_enable;
  logic start_rise;
  logic start_fall;
  logic launch;
  logic tick;
  logic [3:0] bit_idx;
  logic [7:0] fmt_high;
  logic [7:0] fmt_low;

  // Field views of the control registers
  assign start_bit = ctrl0_q[ACS_START_POS];
  assign conv_power_enable = ctrl0_q[ACS_POWER_POS];
  assign external_channel_select = ctrl0_q[ACS_CHAN_POS +: 4];
  assign conv_clock_select = ctrl1_q[ACS_CLKSEL_POS +: 3];
  assign input_source_select = ctrl1_q[ACS_SRC_POS +: 4];
  assign result_format_select = ctrl1_q[ACS_FMT_POS];
  assign reference_select = ctrl2_q[ACS_REF_POS +: 2];
  assign global_irq_enable = irq_en_q[ACS_GIE_POS];
  assign conv_irq_enable = irq_en_q[ACS_CIE_POS];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  // RQ5 zero-wait slave
  // Every access completes at once, so the core never waits on a conversion
  assign access = psel && penable;
  assign wr_en = access && pwrite && addr_hit;
  assign pready = access;
  assign pslverr = access && !addr_hit;
  assign prdata = prdata_q;

  always_comb begin
    addr_hit = (paddr == ACS_CTRL0_OFS) || (paddr == ACS_CTRL1_OFS) ||
               (paddr == ACS_CTRL2_OFS) || (paddr == ACS_RESH_OFS) ||
               (paddr == ACS_RESL_OFS) || (paddr == ACS_IRQ_OFS);
  end

  // Read mux; unused bits read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (paddr)
      ACS_CTRL0_OFS: begin
        rd_data[5:0] = ctrl0_q;
        rd_data[ACS_BUSY_POS] = conv_busy_flag_q;
      end
      ACS_CTRL1_OFS: rd_data[8:0] = ctrl1_q;
      ACS_CTRL2_OFS: rd_data[6:0] = ctrl2_q;
      ACS_RESH_OFS: rd_data[7:0] = result_high_byte_q;
      ACS_RESL_OFS: rd_data[7:0] = result_low_byte_q;
      ACS_IRQ_OFS: begin
        rd_data[1:0] = irq_en_q;
        rd_data[ACS_REQ_POS] = conv_irq_request_q;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  // RQ20 reset powers down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= ACS_CTRL0_RST;
      ctrl1_q <= ACS_CTRL1_RST;
      ctrl2_q <= ACS_CTRL2_RST;
      irq_en_q <= ACS_IRQ_RST;
    end else if (wr_en) begin
      if (paddr == ACS_CTRL0_OFS) begin
        ctrl0_q <= pwdata[5:0];
      end
      if (paddr == ACS_CTRL1_OFS) begin
        ctrl1_q <= pwdata[8:0];
      end
      if (paddr == ACS_CTRL2_OFS) begin
        ctrl2_q <= pwdata[6:0];
      end
      if (paddr == ACS_IRQ_OFS) begin
        irq_en_q <= pwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start bit edges
  // RQ2 low-high-low pulse
  // A fall can only follow a rise, so the full pulse is implied
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_bit;
    end
  end

  assign start_rise = start_bit && !start_prev_q;
  assign start_fall = !start_bit && start_prev_q;
  // RQ7 launch needs power
  assign launch = start_fall && conv_power_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_sync_q <= 3'h0;
      comp_q <= 1'b0;
    end else begin
      comp_sync_q <= {comp_sync_q[1:0], comparator_high};
      if (comp_sync_q[1] == comp_sync_q[2]) begin
        comp_q <= comp_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock
  // RQ6 divided period tick
  acs_clock_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .restart(launch || start_rise),
    .clock_sel(conv_clock_select),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and successive approximation
  // Slow periods leave settling to the analog core; the sync adds 4 cycles
  assign bit_idx = ACS_MSB_INDEX - period_q;

  // RQ1 sample then convert
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ACS_IDLE;
      period_q <= 4'h0;
      sar_q <= ACS_CODE_RST;
    end else if (start_rise || !conv_power_enable) begin
      // RQ19 rise aborts sequencer
      state_q <= ACS_IDLE;
      period_q <= 4'h0;
    end else if (launch) begin
      state_q <= ACS_SAMPLE;
      period_q <= 4'h0;
    end else begin
      unique case (state_q)
        ACS_IDLE: begin
          period_q <= 4'h0;
        end
        ACS_SAMPLE: begin
          if (tick) begin
            if (period_q == ACS_SAMPLE_LAST) begin
              state_q <= ACS_CONVERT;
              period_q <= 4'h0;
              sar_q <= ACS_CODE_RST;
            end else begin
              period_q <= period_q + 4'h1;
            end
          end
        end
        ACS_CONVERT: begin
          // RQ14 one bit per period
          if (tick) begin
            sar_q[bit_idx] <= comp_q;
            if (period_q == ACS_CONVERT_LAST) begin
              state_q <= ACS_DONE;
            end else begin
              period_q <= period_q + 4'h1;
            end
          end
        end
        ACS_DONE: begin
          state_q <= ACS_IDLE;
        end
      endcase
    end
  end

  // RQ18 busy on launch
  // RQ3 busy held throughout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_busy_flag_q <= 1'b0;
    end else if (start_rise || !conv_power_enable) begin
      conv_busy_flag_q <= 1'b0;
    end else if (launch) begin
      // A launch in the done cycle must keep busy high
      conv_busy_flag_q <= 1'b1;
    end else if (state_q == ACS_DONE) begin
      conv_busy_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result bytes
  acs_result_format u_format (
    .code(sar_q),
    .format_sel(result_format_select),
    .high_byte(fmt_high),
    .low_byte(fmt_low)
  );

  // RQ4 results on completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_byte_q <= ACS_BYTE_RST;
      result_low_byte_q <= ACS_BYTE_RST;
    end else if (state_q == ACS_DONE) begin
      result_high_byte_q <= fmt_high;
      result_low_byte_q <= fmt_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request flag
  // RQ16 set on completion
  // Writing zero clears; a completion in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_irq_request_q <= 1'b0;
    end else if (state_q == ACS_DONE) begin
      conv_irq_request_q <= 1'b1;
    end else if (wr_en && paddr == ACS_IRQ_OFS && !pwdata[ACS_REQ_POS]) begin
      conv_irq_request_q <= 1'b0;
    end
  end

  // RQ13 both enables gate
  assign conv_irq = conv_irq_request_q && global_irq_enable &&
                    conv_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls
  always_comb begin
    // RQ8 power follows enable
    analog_ctrl.power_on = conv_power_enable;
    analog_ctrl.sample_hold = (state_q == ACS_SAMPLE);
    // RQ9 external routing
    // RQ10 internal disconnects pin
    analog_ctrl.ext_connect = conv_power_enable &&
                              acs_is_external(input_source_select);
    analog_ctrl.source_sel = input_source_select;
    analog_ctrl.channel_sel = external_channel_select;
    // RQ12 reference and amplifier
    analog_ctrl.reference_sel = reference_select;
    analog_ctrl.amp_input = ctrl2_q[ACS_AMPIN_POS +: 2];
    analog_ctrl.amp_gain = ctrl2_q[ACS_GAIN_POS +: 3];
    analog_ctrl.trial_code = (state_q == ACS_CONVERT) ?
                             (sar_q | (12'h001 << bit_idx)) : sar_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_launch;
    start_prev_q && !start_bit && conv_power_enable;
  endsequence

  sequence s_sample_entry;
    state_q == ACS_SAMPLE && period_q == 4'h0 && conv_busy_flag_q;
  endsequence

  a_busy_on_launch: assert property (s_launch |=> s_sample_entry) // RQ18
    else $error("launch did not enter sampling with busy set");
  a_sample_length: assert property ( // RQ1
    (state_q == ACS_SAMPLE && tick && period_q == ACS_SAMPLE_LAST
     && !start_bit && !start_prev_q && conv_power_enable)
    |=> state_q == ACS_CONVERT)
    else $error("sampling did not last four periods");
  a_convert_length: assert property ( // RQ1
    (state_q == ACS_CONVERT && tick && period_q == ACS_CONVERT_LAST
     && !start_bit && !start_prev_q && conv_power_enable)
    |=> state_q == ACS_DONE)
    else $error("conversion did not end after twelve periods");
  a_done_results: assert property ( // RQ4
    (state_q == ACS_DONE && !start_rise && !launch && conv_power_enable)
    |=> !conv_busy_flag_q && result_low_byte_q == $past(fmt_low))
    else $error("completion did not clear busy or load result");
  a_irq_on_done: assert property (state_q == ACS_DONE |=> // RQ16
    conv_irq_request_q)
    else $error("completion did not set request flag");
  a_irq_gated: assert property (conv_irq |-> global_irq_enable && // RQ13
    conv_irq_enable && conv_irq_request_q)
    else $error("interrupt raised while disabled");
  a_irq_raise: assert property ( // RQ13
    (state_q == ACS_DONE && global_irq_enable && conv_irq_enable && !wr_en)
    |=> conv_irq)
    else $error("enabled completion did not raise interrupt");
  a_rise_aborts: assert property (start_rise |=> // RQ19
    state_q == ACS_IDLE && !conv_busy_flag_q)
    else $error("start rise did not abort");
  a_power_off_idle: assert property ( // RQ8
    !conv_power_enable |-> !analog_ctrl.power_on ##1 state_q == ACS_IDLE)
    else $error("sequencer active while powered off");
  a_busy_held: assert property ((state_q == ACS_CONVERT) |-> // RQ3
    conv_busy_flag_q)
    else $error("busy low during conversion");
  a_ext_disconnect: assert property ( // RQ10
    !acs_is_external(input_source_select) |-> !analog_ctrl.ext_connect)
    else $error("external pin connected for internal source");

endmodule
`default_nettype wire

// file: acs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer over APB.
// Assumes zero-wait APB and the analog core model beside the design.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb;
  import acs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic comp, conv_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cyc, sh_t0, sh_len, irq_len;
  logic [11:0] ext_lvl, int_lvl;
  logic [3:0] chan;
  logic sh_p, irq_p;
  acs_analog_s ac;
  int miscompares, check_count;
  int exp_q[$];

  ////////////////////////////////////////////////////////////////////////////
  // Design and analog partner
  acs_sequencer acs_sequencer_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_high(comp), .analog_ctrl(ac), .conv_irq(conv_irq));
  acs_analog_model acs_analog_model_inst (.pclk(pclk), .ctrl(ac),
    .ext_level(ext_lvl), .int_level(int_lvl), .comparator_high(comp));

  // Clock at 200 MHz
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Phase lengths from cycle stamps; watchdog cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 32'd1;
    sh_p <= ac.sample_hold;
    irq_p <= conv_irq;
    if (ac.sample_hold && !sh_p) sh_t0 <= cyc;
    if (!ac.sample_hold && sh_p) sh_len <= cyc - sh_t0;
    if (conv_irq && !irq_p) irq_len <= cyc - sh_t0;
    if (cyc == 32'd40000) begin
      miscompares++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a,
    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'd0, r, e);
    check(name, r, exp);
  endtask

  // One full conversion; results skipped below select 3, where the
  // comparator synchroniser lag exceeds the converter period
  task automatic convert(input logic [2:0] sel, input logic [3:0] src,
    input logic fmt, input logic [1:0] gi);
    int code;
    logic ext;
    logic [31:0] r;
    logic e;
    ext_lvl = 12'($urandom);
    int_lvl = 12'($urandom);
    if (sel == 3'd3) {ext_lvl, int_lvl} = {12'hfff, 12'hfff};
    if (sel == 3'd4) {ext_lvl, int_lvl} = 24'd0;
    ext = (src == 4'h0) || (src == 4'h4) || (src >= 4'hc);
    exp_q.push_back(ext ? ext_lvl : int_lvl);
    wr(ACS_IRQ_OFS, {30'd0, gi});
    wr(ACS_CTRL1_OFS, {23'd0, fmt, src, 1'b0, sel});
    wr(ACS_CTRL0_OFS, {26'd0, chan, 2'b11});
    rd_chk("busy_after_rise", ACS_CTRL0_OFS, {26'd0, chan, 2'b11});
    wr(ACS_CTRL0_OFS, {26'd0, chan, 2'b10});
    repeat (2) @(posedge pclk);
    rd_chk("busy_run", ACS_CTRL0_OFS, {24'd0, 2'b10, chan, 2'b10});
    @(negedge pclk);
    check("ext_connect", {31'd0, ac.ext_connect}, {31'd0, ext});
    r = 32'h80;
    for (int n = 0; n < 1000 && r[7] !== 1'b0; n++) begin
      apb(1'b0, ACS_CTRL0_OFS, 32'd0, r, e);
    end
    code = exp_q.pop_front();
    if (sel >= 3'd3) begin
      rd_chk("res_high", ACS_RESH_OFS, 32'(fmt ? code >> 8 : code >> 4));
      rd_chk("res_low", ACS_RESL_OFS,
        32'(fmt ? code & 255 : (code & 15) << 4));
    end
    check("sample_len", sh_len, 32'd4 << sel);
    rd_chk("irq_request", ACS_IRQ_OFS, {29'd0, 1'b1, gi});
    check("irq_line", {31'd0, conv_irq}, {31'd0, gi == 2'b11});
    if (gi == 2'b11) check("latency", irq_len, (32'd16 << sel) + 1);
    wr(ACS_IRQ_OFS, {30'd0, gi});
    @(negedge pclk);
    check("irq_cleared", {31'd0, conv_irq}, 32'd0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    logic [6:0] d;
    {presetn, psel, penable, pwrite, sh_p, irq_p} = 6'd0;
    {paddr, pwdata, cyc, sh_t0, sh_len, irq_len} = '0;
    {ext_lvl, int_lvl, chan} = '0;
    void'($urandom(35857));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 6; a++) rd_chk("reset_reg", 8'(a * 4), 32'd0);
    check("power_reset", {31'd0, ac.power_on}, 32'd0);
    // Unmapped offset and read-only result byte
    apb(1'b0, 8'h18, 32'd0, r, e);
    check("unmapped_err", {31'd0, e}, 32'd1);
    check("unmapped_data", r, 32'd0);
    wr(ACS_RESH_OFS, 32'h0000_0055);
    rd_chk("res_readonly", ACS_RESH_OFS, 32'd0);
    d = 7'($urandom);
    wr(ACS_CTRL2_OFS, {25'd0, d});
    rd_chk("ctrl2", ACS_CTRL2_OFS, {25'd0, d});
    @(negedge pclk);
    check("amp_ref", {25'd0, ac.amp_input, ac.amp_gain,
      ac.reference_sel}, {25'd0, d});
    // Every source code with the converter powered
    chan = 4'($urandom);
    wr(ACS_CTRL0_OFS, {26'd0, chan, 2'b10});
    for (int s = 0; s < 16; s++) begin
      wr(ACS_CTRL1_OFS, {24'd0, 4'(s), 4'd0});
      @(negedge pclk);
      check("src_ext", {31'd0, ac.ext_connect},
        32'(s == 0 || s == 4 || s >= 12));
      check("src_sel", {28'd0, ac.source_sel}, 32'(s));
    end
    check("chan_sel", {28'd0, ac.channel_sel}, {28'd0, chan});
    // Every clock select, both formats, all enable pairs
    for (int s = 0; s < 8; s++) begin
      chan = 4'($urandom);
      convert(3'(s), 4'($urandom), 1'(s >> 1), 2'(s));
    end
    // Abort by a new rising edge mid-conversion
    wr(ACS_IRQ_OFS, 32'd0);
    wr(ACS_CTRL1_OFS, 32'h0000_0003);
    wr(ACS_CTRL0_OFS, {26'd0, chan, 2'b11});
    wr(ACS_CTRL0_OFS, {26'd0, chan, 2'b10});
    repeat (20) @(posedge pclk);
    wr(ACS_CTRL0_OFS, {26'd0, chan, 2'b11});
    rd_chk("abort_busy", ACS_CTRL0_OFS, {26'd0, chan, 2'b11});
    repeat (300) @(posedge pclk);
    rd_chk("abort_no_req", ACS_IRQ_OFS, 32'd0);
    // Falling start edge with power off is ignored
    wr(ACS_CTRL0_OFS, {26'd0, chan, 2'b01});
    wr(ACS_CTRL0_OFS, {26'd0, chan, 2'b00});
    repeat (4) @(posedge pclk);
    rd_chk("off_no_busy", ACS_CTRL0_OFS, {26'd0, chan, 2'b00});
    @(negedge pclk);
    check("off_power", {31'd0, ac.power_on}, 32'd0);
    check("off_connect", {31'd0, ac.ext_connect}, 32'd0);
    // Restart after the abort completes normally
    chan = 4'($urandom);
    convert(3'd3, 4'h5, 1'b1, 2'b11);
    give_verdict();
  end
endmodule
`default_nettype wire
